//--- logic/spmc_pkg.sv
// constants, register map and state codes of the serial controller
package spmc_pkg;
    // ======================================================
    // register map (byte addresses)
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_CFG = 4'h8;
    localparam logic [3:0] ADDR_RATE = 4'hC;
    // ======================================================
    // control register fields
    localparam int CTRL_DONE = 7;
    localparam int CTRL_WRITE_COLLISION_FLAG = 6;
    localparam int CTRL_MODE_FAULT_FLAG = 5;
    localparam int CTRL_OVR = 4;
    localparam int CTRL_SELHI = 3;
    localparam int CTRL_SELLO = 2;
    localparam int CTRL_TXE = 1;
    localparam int CTRL_EN = 0;
    // ======================================================
    // config register fields
    localparam int CFG_BUSY = 7;
    localparam int CFG_MST = 6;
    localparam int CFG_PHA = 5;
    localparam int CFG_POL = 4;
    localparam int CFG_SLVSEL = 3;
    localparam int CFG_NSSIN = 2;
    localparam int CFG_SRE = 1;
    localparam int CFG_RXE = 0;
    // ======================================================
    // values after reset and counts
    localparam logic [1:0] RST_SELMODE = 2'h1;
    localparam logic [7:0] RST_RATE = 8'h03;
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_MULTI = 2'h1;
    localparam logic [2:0] BITS_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ======================================================
    // master engine states
    typedef enum logic [1:0] {
        MS_IDLE = 2'b01,
        MS_RUN = 2'b10
    } spmc_mst_t;
endpackage : spmc_pkg

//--- logic/spmc_ctrl.sv
// serial peripheral controller, master or slave, with register slave
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// - master write fills tx buffer; empty shifter takes it and starts
// - master sends on MOSI with SCK, takes MISO msb first, sets done
// - finished byte goes to receive buffer; data read returns it
// - select mode 01 master: NSS low clears enables and sets mode fault
// - after mode fault stay disabled until software sets enables again
// - select mode 00 master: three-wire, NSS unused and not driven
// - select mode 1x master: NSS driven with value of the low select bit
// - enabled non-master in select mode 0x acts as slave, counts edges, done after 8 bits
// - slave write loads shifter if empty, else after current transfer ends
// - four-wire slave active only while NSS low; NSS fall clears counter
// - three-wire slave always selected; only enable toggle clears counter
// - four flags raise a request; only software clears them
// - data write while tx buffer full sets collision, write dropped
// - slave byte ending with unread receive buffer sets overrun, drops it
// - phase picks latching edge, polarity picks clock sense
// - both ends must use matching phase and polarity
// - rate setting used in master only; bit rate at most clock/2
// - polarity 0 idles SCK low, polarity 1 idles SCK high
// - MISO floats when disabled or unselected four-wire slave
// - master drives MOSI from shifter msb in both wire modes
module spmc_ctrl
    import spmc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [spmc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [spmc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic nssIn,
    output logic nssOut,
    output logic nssOe,
    output logic flagRequest
);
    import spmc_pkg::*;

    // ======================================================
    // pin synchronisers
    logic [1:0] sckSy_q, mosiSy_q, misoSy_q, nssSy_q;
    logic sckPrev_q, nssPrev_q;
    wire sckS = sckSy_q[1];
    wire mosiS = mosiSy_q[1];
    wire misoS = misoSy_q[1];
    wire nssS = nssSy_q[1];
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sckSy_q <= 2'h0;
            mosiSy_q <= 2'h0;
            misoSy_q <= 2'h0;
            nssSy_q <= 2'h3;
            sckPrev_q <= 1'b0;
            nssPrev_q <= 1'b1;
        end else begin
            sckSy_q <= {sckSy_q[0], sckIn};
            mosiSy_q <= {mosiSy_q[0], mosiIn};
            misoSy_q <= {misoSy_q[0], misoIn};
            nssSy_q <= {nssSy_q[0], nssIn};
            sckPrev_q <= sckS;
            nssPrev_q <= nssS;
        end
    end

    // ======================================================
    // bus slave handshake
    logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [7:0] wData_q;
    logic wStrb_q;
    logic [1:0] bResp_q, rResp_q;
    logic [7:0] rByte_q;
    wire awTake = awvalid && awReady_q;
    wire wTake = wvalid && wReady_q;
    wire bDone = bValid_q && bready;
    wire arTake = arvalid && arReady_q;
    wire rDone = rValid_q && rready;
    wire wrFire = !awReady_q && !wReady_q && !bValid_q;
    wire wrMapped = awAddr_q == ADDR_DATA || awAddr_q == ADDR_CTRL
        || awAddr_q == ADDR_CFG || awAddr_q == ADDR_RATE;
    wire rdMapped = araddr == ADDR_DATA || araddr == ADDR_CTRL
        || araddr == ADDR_CFG || araddr == ADDR_RATE;
    // only byte lane 0 carries register bits
    wire wrOn = wrFire && wStrb_q;
    wire wrData = wrOn && awAddr_q == ADDR_DATA;
    wire wrCtrl = wrOn && awAddr_q == ADDR_CTRL;
    wire wrCfg = wrOn && awAddr_q == ADDR_CFG;
    wire wrRate = wrOn && awAddr_q == ADDR_RATE;
    wire rdData = arTake && araddr == ADDR_DATA;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            bValid_q <= 1'b0;
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
        end else begin
            awReady_q <= bDone || (awReady_q && !awvalid);
            wReady_q <= bDone || (wReady_q && !wvalid);
            bValid_q <= wrFire || (bValid_q && !bready);
            arReady_q <= rDone || (arReady_q && !arvalid);
            rValid_q <= arTake || (rValid_q && !rready);
        end
    end

    // ======================================================
    // control and configuration state
    logic en_q, mst_q, pha_q, pol_q;
    logic [1:0] sel_q;
    logic [7:0] rate_q;
    logic done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q;
    logic [7:0] txBuf_q, sh_q, rxBuf_q;
    logic txFull_q, shFull_q, rxFull_q, inBit_q, busy_q, lvl_q;
    logic [2:0] cnt_q;
    logic [7:0] div_q;
    spmc_mst_t state_q;

    wire threeWire = sel_q == SEL_3WIRE;
    wire master = en_q && mst_q;
    wire selected = threeWire || !nssS;
    wire slvAct = en_q && !mst_q && !sel_q[1] && selected;
    wire modeFault = master && sel_q == SEL_MULTI && !nssS;
    wire running = state_q == MS_RUN;
    wire tick = running && div_q == rate_q;
    // the synchronised SCK is seen in its active sense
    wire effNow = sckS ^ pol_q;
    wire effOld = sckPrev_q ^ pol_q;
    wire lead = master ? (tick && !lvl_q) : (slvAct && effNow && !effOld);
    wire trail = master ? (tick && lvl_q) : (slvAct && !effNow && effOld);
    wire inPin = master ? misoS : mosiS;
    wire sampleEn = (lead && !pha_q) || (trail && pha_q);
    // phase 1 keeps the msb on the first leading edge
    wire shiftEn = (lead && pha_q && cnt_q != 3'h0) || (trail && !pha_q);
    wire last = trail && cnt_q == BITS_LAST;
    wire [7:0] rxByte = {sh_q[6:0], pha_q ? inPin : inBit_q};
    wire loadMst = master && !running && txFull_q;
    wire loadSlv = en_q && !mst_q && txFull_q && !shFull_q
        && !busy_q;
    wire nssFall = nssPrev_q && !nssS;
    wire cntClr = !en_q || (!mst_q && sel_q == SEL_MULTI && nssFall);
    wire collide = wrData && txFull_q;
    wire overrun = last && !mst_q && rxFull_q;

    wire [7:0] sh_d = (loadMst || loadSlv) ? txBuf_q :
        last ? rxByte :
        shiftEn ? {sh_q[6:0], inBit_q} : sh_q;
    wire lvl_d = !master ? 1'b0 : tick ? !lvl_q : lvl_q;
    wire done_d = last || (wrCtrl ? wData_q[CTRL_DONE] && done_q : done_q);
    wire write_collision_flag_d = collide
        || (wrCtrl ? wData_q[CTRL_WRITE_COLLISION_FLAG] && write_collision_flag_q : write_collision_flag_q);
    wire mode_fault_flag_d = modeFault
        || (wrCtrl ? wData_q[CTRL_MODE_FAULT_FLAG] && mode_fault_flag_q : mode_fault_flag_q);
    wire ovr_d = overrun || (wrCtrl ? wData_q[CTRL_OVR] && ovr_q : ovr_q);
    // fault wins over a software enable in the same cycle
    wire en_d = modeFault ? 1'b0 : wrCtrl ? wData_q[CTRL_EN] : en_q;
    wire mst_d = modeFault ? 1'b0 : wrCfg ? wData_q[CFG_MST] : mst_q;
    wire rxFill = last && !overrun;
    wire [7:0] ctrlRd = {done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, sel_q,
        !txFull_q, en_q};
    wire [7:0] cfgRd = {busy_q, mst_q, pha_q, pol_q, !nssS, nssS,
        mst_q || !shFull_q, mst_q || !rxFull_q};
    wire [7:0] rdByte = araddr == ADDR_DATA ? rxBuf_q :
        araddr == ADDR_CTRL ? ctrlRd :
        araddr == ADDR_CFG ? cfgRd :
        araddr == ADDR_RATE ? rate_q : 8'h00;

    // ======================================================
    // bus capture and read data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            awAddr_q <= '0;
            wData_q <= 8'h00;
            wStrb_q <= 1'b0;
            bResp_q <= RESP_OKAY;
            rResp_q <= RESP_OKAY;
            rByte_q <= 8'h00;
        end else begin
            if (awTake) awAddr_q <= awaddr;
            if (wTake) wData_q <= wdata[7:0];
            if (wTake) wStrb_q <= wstrb[0];
            if (wrFire) bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            if (arTake) rResp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            if (arTake) rByte_q <= rdByte;
        end
    end

    // ======================================================
    // software settings and flags
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_q <= 1'b0;
            mst_q <= 1'b0;
            pha_q <= 1'b0;
            pol_q <= 1'b0;
            sel_q <= RST_SELMODE;
            rate_q <= RST_RATE;
            done_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
            mode_fault_flag_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            en_q <= en_d;
            mst_q <= mst_d;
            if (wrCfg) pha_q <= wData_q[CFG_PHA];
            if (wrCfg) pol_q <= wData_q[CFG_POL];
            if (wrCtrl) sel_q <= wData_q[CTRL_SELHI:CTRL_SELLO];
            if (wrRate) rate_q <= wData_q;
            done_q <= done_d;
            write_collision_flag_q <= write_collision_flag_d;
            mode_fault_flag_q <= mode_fault_flag_d;
            ovr_q <= ovr_d;
        end
    end

    // ======================================================
    // buffers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            txBuf_q <= 8'h00;
            txFull_q <= 1'b0;
            rxBuf_q <= 8'h00;
            rxFull_q <= 1'b0;
            shFull_q <= 1'b0;
        end else begin
            if (wrData && !txFull_q) txBuf_q <= wData_q;
            txFull_q <= (wrData && !txFull_q)
                || (txFull_q && !loadMst && !loadSlv);
            if (rxFill) rxBuf_q <= rxByte;
            rxFull_q <= rxFill || (rxFull_q && !rdData);
            shFull_q <= en_q && (loadSlv || (shFull_q && !last));
        end
    end

    // ======================================================
    // shift engine, shared by master and slave
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sh_q <= 8'h00;
            inBit_q <= 1'b0;
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            if (sampleEn) inBit_q <= inPin;
            if (cntClr) begin
                cnt_q <= 3'h0;
            end else if (trail) begin
                cnt_q <= cnt_q + 3'h1;
            end
            busy_q <= !cntClr && !last
                && (busy_q || lead || trail || loadMst);
        end
    end

    // ======================================================
    // master clock divider; the rate register is unused as slave
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= MS_IDLE;
            div_q <= 8'h00;
            lvl_q <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            div_q <= (running && !tick) ? div_q + 8'h01 : 8'h00;
            case (state_q)
                MS_IDLE: begin
                    if (loadMst) state_q <= MS_RUN;
                end
                MS_RUN: begin
                    if (!master || last) state_q <= MS_IDLE;
                end
                default: begin
                    state_q <= MS_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // registered pin and bus outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sckOut <= 1'b0;
            sckOe <= 1'b0;
            mosiOut <= 1'b0;
            mosiOe <= 1'b0;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
            nssOut <= 1'b0;
            nssOe <= 1'b0;
            flagRequest <= 1'b0;
        end else begin
            sckOut <= pol_q ^ lvl_d;
            sckOe <= en_d && mst_d;
            mosiOut <= sh_d[7];
            mosiOe <= en_d && mst_d;
            misoOut <= sh_d[7];
            misoOe <= slvAct;
            nssOut <= sel_q[0];
            nssOe <= mst_q && sel_q[1];
            flagRequest <= done_d || write_collision_flag_d || mode_fault_flag_d || ovr_d;
        end
    end
    assign awready = awReady_q;
    assign wready = wReady_q;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign arready = arReady_q;
    assign rvalid = rValid_q;
    assign rresp = rResp_q;
    assign rdata = {24'h000000, rByte_q};
endmodule : spmc_ctrl

//--- dv/spmc_ctrl_asserts.sv
// port assertions for the serial controller
`timescale 1ns/1ps
module spmc_ctrl_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic sckOe,
    input wire logic mosiOe,
    input wire logic misoOe,
    input wire logic nssOe,
    input wire logic flagRequest
);
    // ======================================================
    // relations between ports
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    wr_answer_a: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer not on time");
    wr_block_a: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    rd_answer_a: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer not on time");
    rd_block_a: assert property (
        rvalid |-> !arready)
        else $error("read taken while answer pending");
    // only a bus write may clear a flag
    flag_clear_a: assert property (
        $fell(flagRequest) |-> bvalid)
        else $error("flag cleared without a write");
    mosi_drive_a: assert property (
        mosiOe |-> sckOe)
        else $error("data out driven without clock");
    miso_slave_a: assert property (
        misoOe |-> !sckOe && !mosiOe)
        else $error("slave output while master");
    nss_master_a: assert property (
        nssOe |-> !misoOe)
        else $error("select driven by a slave");
endmodule : spmc_ctrl_asserts

bind spmc_ctrl spmc_ctrl_asserts chk (.clock(clock), .nrst(nrst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .sckOe(sckOe), .mosiOe(mosiOe), .misoOe(misoOe), .nssOe(nssOe),
    .flagRequest(flagRequest));

//--- dv/spmc_peer.sv
// far-side device model: shift-register slave or paced master
`timescale 1ns/1ps
module spmc_peer (
    input wire logic clock,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    output logic pSck,
    output logic pMosi,
    output logic pNss,
    output logic slvOe,
    output logic mstOe
);
    // ======================================================
    // phase 0, polarity 0 only
    logic [7:0] sr;
    logic inBit;
    logic [7:0] got;
    initial begin
        {pSck, pMosi, slvOe, mstOe, inBit} = '0;
        got = 8'h00;
        pNss = 1'b1;
        sr = 8'hA5;
    end
    always @(posedge sck) if (slvOe) inBit <= mosi;
    always @(negedge sck) if (slvOe) sr <= {sr[6:0], inBit};
    task automatic setup(input logic s, input logic n);
        slvOe <= s;
        pNss <= n;
    endtask : setup
    // paced from the system clock; h is the half period in clocks:
    // 5 keeps full duplex legal, 2 only when MISO is ignored
    task automatic sendByte(input logic [7:0] b, input int h);
        mstOe <= 1'b1;
        pNss <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = 7; i >= 0; i--) begin
            pMosi <= b[i];
            repeat (h) @(posedge clock);
            pSck <= 1'b1;
            got <= {got[6:0], miso};
            repeat (h) @(posedge clock);
            pSck <= 1'b0;
        end
        repeat (8) @(posedge clock);
        pNss <= 1'b1;
        mstOe <= 1'b0;
        // NSS stays high a while so the next byte brings a clean fall
        repeat (4) @(posedge clock);
    endtask : sendByte
endmodule : spmc_peer

//--- dv/spmc_ctrl_tb.sv
// self-checking bench for the serial controller
`timescale 1ns/1ps
`define CHK(a, b) begin \
    check_count++; \
    if ((a) !== (b)) begin \
        mismatches++; \
        $display("[ERR] %0t value differs", $time); \
    end \
end
module spmc_ctrl_tb;
    import spmc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, flagRequest;
    logic [1:0] bresp, rresp, lastResp;
    logic [31:0] rdata, d;
    logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, nssOut, nssOe;
    logic pSck, pMosi, pNss, slvOe, mstOe;
    wire sckW, mosiW, misoW, nssW;
    int mismatches = 0;
    int check_count = 0;
    always #20 clock = ~clock;
    // released MOSI and MISO toggle so a stale level is never read as data
    assign sckW = sckOe ? sckOut : pSck;
    assign mosiW = mosiOe ? mosiOut : (mstOe ? pMosi : clock);
    assign misoW = misoOe ? misoOut : (slvOe ? peer.sr[7] : clock);
    assign nssW = nssOe ? nssOut : pNss;
    spmc_ctrl dut (.clock(clock), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe),
        .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW),
        .misoOut(misoOut), .misoOe(misoOe), .nssIn(nssW), .nssOut(nssOut),
        .nssOe(nssOe), .flagRequest(flagRequest));
    spmc_peer peer (.clock(clock), .sck(sckW), .mosi(mosiW), .miso(misoW),
        .pSck(pSck), .pMosi(pMosi), .pNss(pNss), .slvOe(slvOe),
        .mstOe(mstOe));
    // ======================================================
    // bus tasks
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(posedge clock);
        while (awvalid || wvalid) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge clock);
        end
        while (!bvalid) @(posedge clock);
        lastResp = bresp;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clock);
        while (!arready) @(posedge clock);
        arvalid <= 1'b0;
        @(posedge clock);
        while (!rvalid) @(posedge clock);
        v = rdata;
        lastResp = rresp;
    endtask : rd
    task automatic rc(input logic [3:0] a, input logic [7:0] m,
            input logic [7:0] e);
        rd(a, d);
        `CHK(d[7:0] & m, e)
    endtask : rc
    task automatic waitIdle();
        logic [31:0] c;
        do begin
            rd(ADDR_CTRL, c);
            rd(ADDR_CFG, d);
        end while (!c[CTRL_TXE] || d[CFG_BUSY]);
    endtask : waitIdle
    task automatic end_sim();
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        #2000000;
        mismatches++;
        end_sim();
    end
    // ======================================================
    // scenarios
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rc(ADDR_CTRL, 8'hFF, 8'h06);
        rc(ADDR_CFG, 8'hFF, 8'h07);
        rc(ADDR_RATE, 8'hFF, 8'h03);
        rd(4'h2, d);
        `CHK(lastResp, RESP_SLVERR)
        wr(4'h2, 8'h00);
        `CHK(lastResp, RESP_SLVERR)
        `CHK(misoOe, 1'b0)
        peer.setup(1'b1, 1'b1);
        wr(ADDR_RATE, 8'h07);
        wr(ADDR_CFG, 8'h40);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_DATA, 8'h3C);
        `CHK(lastResp, RESP_OKAY)
        wr(ADDR_DATA, 8'hC3);
        wr(ADDR_DATA, 8'h77);
        waitIdle();
        `CHK(peer.sr, 8'hC3)
        rc(ADDR_DATA, 8'hFF, 8'h3C);
        rc(ADDR_CTRL, 8'hC0, 8'hC0);
        `CHK(flagRequest, 1'b1)
        wr(ADDR_CTRL, 8'h01);
        `CHK(flagRequest, 1'b0)
        `CHK(sckOut, 1'b0)
        wr(ADDR_CFG, 8'h50);
        repeat (2) @(posedge clock);
        `CHK(sckOut, 1'b1)
        wr(ADDR_CFG, 8'h40);
        wr(ADDR_CTRL, 8'h09);
        repeat (2) @(posedge clock);
        `CHK({nssOe, nssOut}, 2'b10)
        wr(ADDR_CTRL, 8'h0D);
        repeat (2) @(posedge clock);
        `CHK({nssOe, nssOut}, 2'b11)
        wr(ADDR_CTRL, 8'h01);
        repeat (2) @(posedge clock);
        `CHK(nssOe, 1'b0)
        // multi-master: another master takes the bus
        wr(ADDR_CTRL, 8'h05);
        peer.setup(1'b1, 1'b0);
        repeat (6) @(posedge clock);
        rc(ADDR_CTRL, 8'h21, 8'h20);
        rc(ADDR_CFG, 8'h40, 8'h00);
        peer.setup(1'b0, 1'b1);
        repeat (10) @(posedge clock);
        rc(ADDR_CTRL, 8'h21, 8'h20);
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_CTRL, 8'h05);
        repeat (2) @(posedge clock);
        `CHK(misoOe, 1'b0)
        wr(ADDR_DATA, 8'h5A);
        peer.sendByte(8'h96, 5);
        `CHK(peer.got, 8'h5A)
        peer.sendByte(8'h69, 5);
        rc(ADDR_CTRL, 8'h90, 8'h90);
        rc(ADDR_DATA, 8'hFF, 8'h96);
        // three-wire slave ignores NSS; receive only, so the fast rate
        wr(ADDR_CTRL, 8'h01);
        peer.sendByte(8'hE1, 2);
        rc(ADDR_DATA, 8'hFF, 8'hE1);
        end_sim();
    end
endmodule : spmc_ctrl_tb
